// File: shared/flash_seq_pkg.sv
package flash_seq_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock
  localparam int CLK_MHZ       = 25;
  localparam int CLK_PERIOD_NS = 40;

  ////////////////////////////////////////////////////////////////////////////
  // Times in their own units
  localparam int POWER_UP_WAIT_US        = 300;
  localparam int RECOVERY_INTERVAL_US    = 35;
  localparam int MIN_PULSE_WIDTH_NS      = 200;
  localparam int PRE_ASSERT_HIGH_TIME_NS = 50;
  localparam int POST_RELEASE_HOLD_NS    = 50;

  ////////////////////////////////////////////////////////////////////////////
  // Cycle counts: longest times round down, least times round up
  localparam int POWER_UP_WAIT_CYC = (POWER_UP_WAIT_US * CLK_MHZ) < 1 ? 1 :
                                     (POWER_UP_WAIT_US * CLK_MHZ);
  localparam int RECOVERY_CYC      = RECOVERY_INTERVAL_US * CLK_MHZ;
  localparam int MIN_PULSE_CYC     = (MIN_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRE_ASSERT_CYC    = (PRE_ASSERT_HIGH_TIME_NS + CLK_PERIOD_NS - 1)
                                     / CLK_PERIOD_NS;
  localparam int POST_HOLD_CYC     = (POST_RELEASE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Host pulse chosen so that pulse plus hold covers the recovery interval
  localparam int HOST_PULSE_CYC    = (RECOVERY_CYC - POST_HOLD_CYC) > MIN_PULSE_CYC ?
                                     (RECOVERY_CYC - POST_HOLD_CYC) : MIN_PULSE_CYC;

  ////////////////////////////////////////////////////////////////////////////
  // Counters
  localparam int CNT_W = 16;
  typedef logic [CNT_W-1:0] count_t;
  localparam count_t CNT_ZERO = 16'h0000;
  localparam count_t CNT_ONE  = 16'h0001;

  ////////////////////////////////////////////////////////////////////////////
  // States
  typedef enum logic [2:0] {
    DEV_OFF,
    DEV_COLD,
    DEV_FAIL,
    DEV_HELD,
    DEV_READY,
    DEV_WARM
  } dev_state_t;

  typedef enum logic [1:0] {
    HST_POWER,
    HST_IDLE,
    HST_PULSE,
    HST_HOLD
  } host_state_t;

endpackage

// File: shared/flash_reset_if.sv
`timescale 1ns/1ps
interface flash_reset_if;
  logic cs_n;
  logic reset_n;

  modport host (
    output cs_n,
    output reset_n
  );

  modport dev (
    input cs_n,
    input reset_n
  );
endinterface

// File: verilog/flash_reset_host.sv
`timescale 1ns/1ps
module flash_reset_host (
  input  wire logic    CLK_SYS,
  input  wire logic    RSTN,
  input  wire logic    CE,
  input  wire logic    SUPPLY_OK,
  input  wire logic    SELECT_REQ,
  input  wire logic    RESET_REQ,
  flash_reset_if.host  LINK,
  output logic         HOST_READY,
  output logic         RESET_BUSY
);

  ////////////////////////////////////////////////////////////////////////////
  // Supply level comes from outside the clock domain
  logic [1:0]                 supply_sync_reg;
  logic                       supply_s;
  flash_seq_pkg::host_state_t state_reg;
  flash_seq_pkg::count_t      cnt_reg;
  flash_seq_pkg::count_t      high_cnt_reg;
  logic                       pend_reg;
  logic                       cs_n_reg;
  logic                       rst_n_reg;
  logic                       take_reset;

  assign supply_s     = supply_sync_reg[1];
  assign LINK.cs_n    = cs_n_reg;
  assign LINK.reset_n = rst_n_reg;
  assign take_reset   = (state_reg == flash_seq_pkg::HST_IDLE) && pend_reg &&
                        (high_cnt_reg >= 16'(flash_seq_pkg::PRE_ASSERT_CYC));

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      supply_sync_reg <= '0;
    end else if (CE) begin
      supply_sync_reg <= {supply_sync_reg[0], SUPPLY_OK};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request latch: a new request wins over the clear
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      pend_reg <= 1'b0;
    end else if (CE) begin
      pend_reg <= RESET_REQ || (pend_reg && !take_reset);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      state_reg    <= flash_seq_pkg::HST_POWER;
      cnt_reg      <= flash_seq_pkg::CNT_ZERO;
      high_cnt_reg <= flash_seq_pkg::CNT_ZERO;
      cs_n_reg     <= 1'b1;
      rst_n_reg    <= 1'b1;
    end else if (CE) begin
      case (state_reg)
        flash_seq_pkg::HST_POWER: begin
          cs_n_reg     <= 1'b1;
          high_cnt_reg <= flash_seq_pkg::CNT_ZERO;
          if (!supply_s) begin
            cnt_reg <= flash_seq_pkg::CNT_ZERO;
          end else if (cnt_reg == 16'(flash_seq_pkg::POWER_UP_WAIT_CYC - 1)) begin
            state_reg <= flash_seq_pkg::HST_IDLE;
            cnt_reg   <= flash_seq_pkg::CNT_ZERO;
          end else begin
            cnt_reg <= cnt_reg + flash_seq_pkg::CNT_ONE;
          end
        end
        flash_seq_pkg::HST_IDLE: begin
          if (high_cnt_reg < 16'(flash_seq_pkg::PRE_ASSERT_CYC)) begin
            high_cnt_reg <= high_cnt_reg + flash_seq_pkg::CNT_ONE;
          end
          if (!supply_s) begin
            state_reg <= flash_seq_pkg::HST_POWER;
            cs_n_reg  <= 1'b1;
          end else if (take_reset) begin
            state_reg <= flash_seq_pkg::HST_PULSE;
            rst_n_reg <= 1'b0;
            cs_n_reg  <= 1'b1;
            cnt_reg   <= flash_seq_pkg::CNT_ZERO;
          end else begin
            cs_n_reg <= !SELECT_REQ;
          end
        end
        flash_seq_pkg::HST_PULSE: begin
          cs_n_reg <= 1'b1;
          if (cnt_reg == 16'(flash_seq_pkg::HOST_PULSE_CYC - 1)) begin
            state_reg <= flash_seq_pkg::HST_HOLD;
            rst_n_reg <= 1'b1;
            cnt_reg   <= flash_seq_pkg::CNT_ZERO;
          end else begin
            cnt_reg <= cnt_reg + flash_seq_pkg::CNT_ONE;
          end
        end
        flash_seq_pkg::HST_HOLD: begin
          cs_n_reg <= 1'b1;
          if (cnt_reg == 16'(flash_seq_pkg::POST_HOLD_CYC - 1)) begin
            state_reg    <= flash_seq_pkg::HST_IDLE;
            cnt_reg      <= flash_seq_pkg::CNT_ZERO;
            high_cnt_reg <= flash_seq_pkg::CNT_ZERO;
          end else begin
            cnt_reg <= cnt_reg + flash_seq_pkg::CNT_ONE;
          end
        end
        default: begin
          state_reg <= flash_seq_pkg::HST_POWER;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      HOST_READY <= 1'b0;
      RESET_BUSY <= 1'b0;
    end else if (CE) begin
      HOST_READY <= (state_reg == flash_seq_pkg::HST_IDLE);
      RESET_BUSY <= pend_reg || (state_reg == flash_seq_pkg::HST_PULSE) ||
                    (state_reg == flash_seq_pkg::HST_HOLD);
    end
  end

endmodule // flash_reset_host

// File: verilog/flash_reset_dev.sv
// What this block does
// - Chip select low means active power
// - Stay active until pending operations finish
// - Cold reset runs power-up wait after supply
// - Power-up wait at most 300 microseconds
// - Host keeps select high during power-up
// - Reset pin ignored during cold reset
// - Reset low at end stays reset
// - Host holds reset high 50 ns first
// - Reset falling edge starts 35 us warm
// - Failed cold reset restarts on reset low
// - 200 ns low aborts, tri-states, ignores commands
// - Host raises select during recovery interval
// - Pulse plus hold covers recovery interval
// - End of power-up: standby, latch cleared
`timescale 1ns/1ps
module flash_reset_dev #(
  parameter int POWER_UP_CYC = flash_seq_pkg::POWER_UP_WAIT_CYC
) (
  input  wire logic    CLK_SYS,
  input  wire logic    RSTN,
  input  wire logic    CE,
  input  wire logic    SUPPLY_OK,
  input  wire logic    OP_PENDING,
  flash_reset_if.dev   LINK,
  output logic         ACTIVE_POWER,
  output logic         CMD_READY,
  output logic         OUT_EN,
  output logic         ABORT_OP,
  output logic         REG_INIT,
  output logic         WEL_CLEAR,
  output logic         POR_DONE
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [1:0]                cs_sync_reg;
  logic [1:0]                rst_sync_reg;
  logic [1:0]                supply_sync_reg;
  logic                      cs_s;
  logic                      rst_s;
  logic                      supply_s;
  logic                      rst_d_reg;
  logic                      rst_fall;
  flash_seq_pkg::dev_state_t state_reg;
  flash_seq_pkg::count_t     cnt_reg;
  flash_seq_pkg::count_t     low_cnt_reg;
  logic                      cold_end;
  logic                      warm_start;
  logic                      pulse_long;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only stage 1 is read by logic
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      cs_sync_reg     <= 2'h3;
      rst_sync_reg    <= 2'h3;
      supply_sync_reg <= 2'h0;
    end else if (CE) begin
      cs_sync_reg     <= {cs_sync_reg[0], LINK.cs_n};
      rst_sync_reg    <= {rst_sync_reg[0], LINK.reset_n};
      supply_sync_reg <= {supply_sync_reg[0], SUPPLY_OK};
    end
  end

  assign cs_s     = cs_sync_reg[1];
  assign rst_s    = rst_sync_reg[1];
  assign supply_s = supply_sync_reg[1];

  // Edge detector looks only at the settled stage
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      rst_d_reg <= 1'b1;
    end else if (CE) begin
      rst_d_reg <= rst_s;
    end
  end

  assign rst_fall = rst_d_reg && !rst_s;

  ////////////////////////////////////////////////////////////////////////////
  // Reset pulse width measure
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      low_cnt_reg <= flash_seq_pkg::CNT_ZERO;
    end else if (CE) begin
      if (rst_s) begin
        low_cnt_reg <= flash_seq_pkg::CNT_ZERO;
      end else if (low_cnt_reg < 16'(flash_seq_pkg::MIN_PULSE_CYC)) begin
        low_cnt_reg <= low_cnt_reg + flash_seq_pkg::CNT_ONE;
      end
    end
  end

  // True for one cycle, when the low level reaches the minimum width
  assign pulse_long = !rst_s && (low_cnt_reg == 16'(flash_seq_pkg::MIN_PULSE_CYC - 1));

  assign cold_end   = (state_reg == flash_seq_pkg::DEV_COLD) && supply_s &&
                      (cnt_reg == 16'(POWER_UP_CYC - 1));
  assign warm_start = (state_reg == flash_seq_pkg::DEV_READY) && supply_s && rst_fall;

  ////////////////////////////////////////////////////////////////////////////
  // Reset sequencer
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      state_reg <= flash_seq_pkg::DEV_OFF;
      cnt_reg   <= flash_seq_pkg::CNT_ZERO;
    end else if (CE) begin
      case (state_reg)
        flash_seq_pkg::DEV_OFF: begin
          cnt_reg <= flash_seq_pkg::CNT_ZERO;
          if (supply_s) begin
            state_reg <= flash_seq_pkg::DEV_COLD;
          end
        end
        flash_seq_pkg::DEV_COLD: begin
          // Reset pin not looked at until the wait has run out
          if (!supply_s) begin
            state_reg <= flash_seq_pkg::DEV_FAIL;
            cnt_reg   <= flash_seq_pkg::CNT_ZERO;
          end else if (cold_end) begin
            state_reg <= rst_s ? flash_seq_pkg::DEV_READY
                               : flash_seq_pkg::DEV_HELD;
            cnt_reg   <= flash_seq_pkg::CNT_ZERO;
          end else begin
            cnt_reg <= cnt_reg + flash_seq_pkg::CNT_ONE;
          end
        end
        flash_seq_pkg::DEV_FAIL: begin
          // A broken cold start is only repaired by the reset pin
          cnt_reg <= flash_seq_pkg::CNT_ZERO;
          if (supply_s && !rst_s) begin
            state_reg <= flash_seq_pkg::DEV_COLD;
          end
        end
        flash_seq_pkg::DEV_HELD: begin
          cnt_reg <= flash_seq_pkg::CNT_ZERO;
          if (!supply_s) begin
            state_reg <= flash_seq_pkg::DEV_OFF;
          end else if (rst_s) begin
            state_reg <= flash_seq_pkg::DEV_READY;
          end
        end
        flash_seq_pkg::DEV_READY: begin
          cnt_reg <= flash_seq_pkg::CNT_ZERO;
          if (!supply_s) begin
            state_reg <= flash_seq_pkg::DEV_OFF;
          end else if (warm_start) begin
            state_reg <= flash_seq_pkg::DEV_WARM;
          end
        end
        flash_seq_pkg::DEV_WARM: begin
          if (!supply_s) begin
            state_reg <= flash_seq_pkg::DEV_OFF;
            cnt_reg   <= flash_seq_pkg::CNT_ZERO;
          end else if (cnt_reg >= 16'(flash_seq_pkg::RECOVERY_CYC - 1)) begin
            // Pin still low past recovery keeps the part in reset
            state_reg <= rst_s ? flash_seq_pkg::DEV_READY
                               : flash_seq_pkg::DEV_HELD;
            cnt_reg   <= flash_seq_pkg::CNT_ZERO;
          end else begin
            cnt_reg <= cnt_reg + flash_seq_pkg::CNT_ONE;
          end
        end
        default: begin
          state_reg <= flash_seq_pkg::DEV_OFF;
          cnt_reg   <= flash_seq_pkg::CNT_ZERO;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reinitialise pulses
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      REG_INIT  <= 1'b0;
      WEL_CLEAR <= 1'b0;
      ABORT_OP  <= 1'b0;
    end else if (CE) begin
      REG_INIT  <= cold_end || warm_start;
      WEL_CLEAR <= cold_end || warm_start;
      ABORT_OP  <= pulse_long && (state_reg == flash_seq_pkg::DEV_WARM);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power mode and interface status
  // Pending work keeps the part active even with select high
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      ACTIVE_POWER <= 1'b0;
      CMD_READY    <= 1'b0;
      OUT_EN       <= 1'b0;
      POR_DONE     <= 1'b0;
    end else if (CE) begin
      case (state_reg)
        flash_seq_pkg::DEV_READY: begin
          ACTIVE_POWER <= !cs_s || OP_PENDING;
          CMD_READY    <= rst_s && !rst_fall;
          OUT_EN       <= !cs_s && rst_s;
          POR_DONE     <= 1'b1;
        end
        flash_seq_pkg::DEV_COLD: begin
          ACTIVE_POWER <= 1'b1;
          CMD_READY    <= 1'b0;
          OUT_EN       <= 1'b0;
          POR_DONE     <= 1'b0;
        end
        flash_seq_pkg::DEV_WARM: begin
          ACTIVE_POWER <= 1'b1;
          CMD_READY    <= 1'b0;
          OUT_EN       <= 1'b0;
          POR_DONE     <= 1'b1;
        end
        flash_seq_pkg::DEV_HELD: begin
          ACTIVE_POWER <= 1'b0;
          CMD_READY    <= 1'b0;
          OUT_EN       <= 1'b0;
          POR_DONE     <= 1'b1;
        end
        default: begin
          ACTIVE_POWER <= 1'b0;
          CMD_READY    <= 1'b0;
          OUT_EN       <= 1'b0;
          POR_DONE     <= 1'b0;
        end
      endcase
    end
  end

endmodule // flash_reset_dev

// File: testbench/flash_reset_props.sv
`timescale 1ns/1ps
module flash_reset_props (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic cs_n,
  input wire logic reset_n,
  input wire logic OP_PENDING,
  input wire logic ACTIVE_POWER,
  input wire logic CMD_READY,
  input wire logic OUT_EN,
  input wire logic ABORT_OP,
  input wire logic REG_INIT,
  input wire logic WEL_CLEAR,
  input wire logic POR_DONE
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RSTN);

  ////////////////////////////////////////////////////////////////////////////
  // Pulse length, and time from a warm start until commands return
  logic [15:0] low_cnt_reg;
  logic [15:0] warm_cnt_reg;
  logic        warm_on_reg;

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      low_cnt_reg <= 16'h0000;
    end else begin
      low_cnt_reg <= reset_n ? 16'h0000 : low_cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      warm_cnt_reg <= 16'h0000;
      warm_on_reg  <= 1'b0;
    end else if ($fell(reset_n) && CMD_READY) begin
      warm_cnt_reg <= 16'h0001;
      warm_on_reg  <= 1'b1;
    end else if (warm_on_reg) begin
      warm_cnt_reg <= warm_cnt_reg + 16'h0001;
      // Commands stay up for a few cycles while the pin is synchronised
      warm_on_reg  <= !CMD_READY || warm_cnt_reg < 16'h0008;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_select_active_power: assert property ((!cs_n)[*4] ##0 CMD_READY |-> ACTIVE_POWER)
    else $error("active power missing while selected");
  a_idle_standby: assert property (
      (cs_n && !OP_PENDING && CMD_READY)[*4] |-> !ACTIVE_POWER)
    else $error("standby missing while idle");
  a_pending_active: assert property ((OP_PENDING && CMD_READY)[*2] |-> ACTIVE_POWER)
    else $error("standby entered with pending operation");
  a_cold_refuses: assert property (!POR_DONE |-> !CMD_READY && !OUT_EN && !ABORT_OP)
    else $error("commands taken before power-up ended");
  a_warm_start_init: assert property ($fell(reset_n) && CMD_READY |->
      ##[1:4] (REG_INIT && WEL_CLEAR))
    else $error("warm reset did not reinitialise");
  a_warm_abort: assert property ($fell(reset_n) && CMD_READY |-> ##[5:12] ABORT_OP)
    else $error("abort missing after long reset pulse");
  // Two sync stages and the output flop put the pin three samples back
  a_abort_needs_low: assert property (ABORT_OP |->
      !$past(reset_n, 7) && !$past(reset_n, 3))
    else $error("abort without long reset pulse");
  a_warm_recovery: assert property (warm_on_reg && $rose(CMD_READY) |->
      warm_cnt_reg >= 16'h036B && warm_cnt_reg <= 16'h0374)
    else $error("recovery interval length wrong");
  a_host_pulse_len: assert property ($rose(reset_n) |-> low_cnt_reg == 16'h0369)
    else $error("reset pulse length wrong");
  a_select_high_reset: assert property (!reset_n |-> cs_n)
    else $error("select low during reset pulse");
  a_post_release_hold: assert property ($rose(reset_n) |-> cs_n[*2])
    else $error("select low too soon after reset");
  a_pre_assert_high: assert property ($fell(reset_n) |-> $past(reset_n, 2))
    else $error("reset pin not high long enough");
  a_no_select_cold: assert property (!POR_DONE |-> cs_n)
    else $error("select low during power-up");
endmodule // flash_reset_props

// File: testbench/flash_reset_power_sequencer_tb.sv
`timescale 1ns/1ps
module flash_reset_power_sequencer_tb;
  localparam int PU = 20;
  logic CLK_SYS, RSTN, CE, SUPPLY_OK, SELECT_REQ, RESET_REQ, OP_PENDING;
  logic ACTIVE_POWER, CMD_READY, OUT_EN, ABORT_OP, REG_INIT, WEL_CLEAR, POR_DONE;
  logic HOST_READY, RESET_BUSY;
  int   num_errors = 0;
  int   checked    = 0;
  int   seed       = 42;
  int   aborts     = 0;
  int   inits      = 0;
  int   n;

  flash_reset_if flash_reset_if_i ();
  flash_reset_host flash_reset_host_i (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .CE(CE),
    .SUPPLY_OK(SUPPLY_OK), .SELECT_REQ(SELECT_REQ), .RESET_REQ(RESET_REQ),
    .LINK(flash_reset_if_i.host), .HOST_READY(HOST_READY), .RESET_BUSY(RESET_BUSY));
  flash_reset_dev #(.POWER_UP_CYC(PU)) flash_reset_dev_i (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
    .CE(CE), .SUPPLY_OK(SUPPLY_OK), .OP_PENDING(OP_PENDING), .LINK(flash_reset_if_i.dev),
    .ACTIVE_POWER(ACTIVE_POWER), .CMD_READY(CMD_READY), .OUT_EN(OUT_EN), .ABORT_OP(ABORT_OP),
    .REG_INIT(REG_INIT), .WEL_CLEAR(WEL_CLEAR), .POR_DONE(POR_DONE));
  flash_reset_props flash_reset_props_i (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
    .cs_n(flash_reset_if_i.cs_n), .reset_n(flash_reset_if_i.reset_n), .OP_PENDING(OP_PENDING),
    .ACTIVE_POWER(ACTIVE_POWER), .CMD_READY(CMD_READY), .OUT_EN(OUT_EN), .ABORT_OP(ABORT_OP),
    .REG_INIT(REG_INIT), .WEL_CLEAR(WEL_CLEAR), .POR_DONE(POR_DONE));

  initial begin
    CLK_SYS = 1'b0;
    forever #20 CLK_SYS = ~CLK_SYS;
  end

  // One-cycle pulses are counted here so no test can miss them
  always @(posedge CLK_SYS) begin
    if (ABORT_OP === 1'b1) aborts++;
    if (REG_INIT === 1'b1 && WEL_CLEAR === 1'b1) inits++;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic exp_active(input logic sel, input logic pend);
    return sel | pend;
  endfunction

  task automatic tick(input int k);
    repeat (k) @(posedge CLK_SYS);
    #1;
  endtask

  task automatic check(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic wait_on(input int sel, input logic lvl, input int lim, output int cnt);
    logic v;
    cnt = 0;
    do begin
      tick(1);
      cnt++;
      case (sel)
        0: v = POR_DONE;
        1: v = HOST_READY;
        2: v = CMD_READY;
        default: v = flash_reset_if_i.reset_n;
      endcase
    end while (v !== lvl && cnt < lim);
    if (v !== lvl) begin
      num_errors++;
      $display("[FAIL] wait %0d expected %b seen %b", sel, lvl, v);
      report_and_stop();
    end
  endtask

  task automatic pulse_reset();
    RESET_REQ = 1'b1;
    tick(1);
    RESET_REQ = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    RSTN = 1'b0;
    CE = 1'b1;
    SUPPLY_OK = 1'b0;
    SELECT_REQ = 1'b0;
    RESET_REQ = 1'b0;
    OP_PENDING = 1'b0;
    tick(12);
    RSTN = 1'b1;
    SUPPLY_OK = 1'b1;
    wait_on(0, 1'b1, 100, n);
    check("cold length", 1'b1, n >= PU && n <= PU + 6);
    tick(3);
    check("cold end init", 1'b1, inits == 1);
    check("standby after power-up", 1'b0, ACTIVE_POWER);
    check("commands accepted", 1'b1, CMD_READY);
    SELECT_REQ = 1'b1;
    tick(100);
    check("host select during wait", 1'b1, flash_reset_if_i.cs_n);
    wait_on(1, 1'b1, 8000, n);
    $display("test cold power-up done");

    for (int i = 0; i < 40; i++) begin
      SELECT_REQ = 1'($random(seed));
      OP_PENDING = (i % 5 == 0) ? 1'b1 : 1'($random(seed));
      tick(6 + ($unsigned($random(seed)) % 4));
      check("active power", exp_active(SELECT_REQ, OP_PENDING), ACTIVE_POWER);
    end
    SELECT_REQ = 1'b1;
    OP_PENDING = 1'b1;
    tick(8);
    SELECT_REQ = 1'b0;
    tick(10);
    check("active while pending", 1'b1, ACTIVE_POWER);
    OP_PENDING = 1'b0;
    tick(6);
    check("standby after pending", 1'b0, ACTIVE_POWER);
    // Enable low: a new select must not pass either end
    CE = 1'b0;
    SELECT_REQ = 1'b1;
    tick(10);
    check("select frozen", 1'b1, flash_reset_if_i.cs_n);
    check("power frozen", 1'b0, ACTIVE_POWER);
    CE = 1'b1;
    tick(6);
    check("active after freeze", 1'b1, ACTIVE_POWER);
    $display("test power modes done");

    SELECT_REQ = 1'b1;
    tick(8);
    for (int r = 0; r < 2; r++) begin
      aborts = 0;
      inits = 0;
      tick(6);
      check("outputs driven", 1'b1, OUT_EN);
      pulse_reset();
      wait_on(3, 1'b0, 12, n);
      tick(6);
      check("outputs released", 1'b0, OUT_EN);
      check("select high in reset", 1'b1, flash_reset_if_i.cs_n);
      check("reset busy", 1'b1, RESET_BUSY);
      check("host busy", 1'b0, HOST_READY);
      wait_on(2, 1'b1, 900, n);
      n = n + 6 - flash_seq_pkg::RECOVERY_CYC;
      check("recovery length", 1'b1, n >= 0 && n <= 10);
      check("reset done", 1'b0, RESET_BUSY);
      check("abort pulse", 1'b1, aborts == 1);
      check("warm init", 1'b1, inits == 1);
    end
    $display("test warm reset done");

    SELECT_REQ = 1'b0;
    wait_on(1, 1'b1, 20, n);
    SUPPLY_OK = 1'b0;
    tick(6);
    SUPPLY_OK = 1'b1;
    tick(10);
    // Supply lost in mid power-up leaves it unfinished
    SUPPLY_OK = 1'b0;
    tick(6);
    SUPPLY_OK = 1'b1;
    tick(40);
    check("failed power-up", 1'b0, POR_DONE);
    wait_on(1, 1'b1, 8000, n);
    pulse_reset();
    wait_on(0, 1'b1, 100, n);
    check("full power-up", 1'b1, n >= PU);
    check("held in reset", 1'b0, CMD_READY);
    wait_on(2, 1'b1, 1000, n);
    check("reset pin high", 1'b1, flash_reset_if_i.reset_n);
    $display("test failed power-up done");
    report_and_stop();
  end
endmodule // flash_reset_power_sequencer_tb
